// [hw/sfce_array.sv]
// flip-flop storage array, one write port, one asynchronous read port
// assumes: written and read in the link clock domain; contents are not reset (nonvolatile)
`timescale 1ns/10ps
module sfce_array #(
   parameter int DEPTH = 8192,
   parameter int AW = 13,
   parameter int DW = 8
) (
   input logic clk,
   input logic wr_en,
   input logic [AW-1:0] wr_addr,
   input logic [DW-1:0] wr_data,
   input logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);

   logic [DW-1:0] mem_r [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   assign rd_data = mem_r[rd_addr];

endmodule

// [hw/sfce_sync.sv]
// two-flop level synchroniser with synchronous reset
// assumes: d is a slow level from another clock domain or a pin
`timescale 1ns/10ps
module sfce_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input logic clk,
   input logic rst_n,
   input logic d,
   output logic q
);

   logic meta_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

// [hw/sfce_top.sv]
// serial-slave command engine of an 8k x 8 nonvolatile memory
// assumes: sck/cs_n/si/hold_n/wp_n come from an external master; clk is a free-running 200 MHz clock
// the link side runs on sck; cs_n high (and sleep, power-on) holds its frame logic in reset asynchronously; latch and status bits reset only at power-on
`timescale 1ns/10ps

// How it works
// - an instruction is eight bits; a frame cut short runs nothing.
// - latch-set code sets the write enable latch, latch-clear code clears it.
// - array and status writes are refused while the write enable latch is clear.
// - status read shifts the status byte out on falling edges, repeating every 8 clocks.
// - status write stores one byte; incoming latch bit and zero bit are ignored.
// - array read takes 16 address bits, top 3 ignored, then drives data out.
// - every further 8 clocks returns the next byte, wrapping from top to zero.
// - array write takes an address and commits each complete 8-bit data byte.
// - further complete bytes go to following addresses, wrapping to zero.
// - identity read drives 32 bits: maker, continuation, two product bytes.
// - after the 32nd identity bit the output keeps that bit until deselect.
// - sleep code enters sleep at deselect unless a rising clock edge came first.
// - asleep, clock and input are ignored and the output floats.
// - device is awake at most 400 us after select falls while asleep.
// - two guard bits pick the write-protected top region of the array.
// - status writable unless lock bit set and write-protect pin low; guards always hold.
// - hold low pauses the command, ignores clock and input, floats the output.
// - deselect during hold aborts; the latch keeps its earlier value if unrecognised.
// - modes 0 and 3: sample input on rising edges, drive output on falling edges.
// - deselected, the device is in standby with its output floating.
// - status byte: lock, three spare, two guard, latch, zero; latch clears at power-on.
module sfce_top #(
   parameter int WAKE_CYC = sfce_pkg::WAKE_CYCLES,
   parameter logic [31:0] ID_WORD = sfce_pkg::ID_WORD_DEFAULT,
   parameter int DEPTH = sfce_pkg::ARRAY_DEPTH
) (
   input logic clk,
   input logic rst_n,
   input logic sck,
   input logic cs_n,
   input logic si,
   input logic hold_n,
   input logic wp_n,
   output logic so,
   output logic so_oe,
   output logic asleep
);
   import sfce_pkg::*;

   localparam int AW = ADDR_W;
   localparam int CW = $clog2(WAKE_CYC + 1);
   localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYC - WAKE_OVERHEAD);

   // system clock domain
   logic por_r;
   logic cs_s;
   logic req_s;
   logic cs_prev_r;
   logic asleep_r;
   logic waking_r;
   logic req_used_r;
   logic [CW-1:0] wake_cnt_r;
   logic cs_rise;
   logic cs_fall;
   logic sleep_go;
   logic wake_done;

   // link clock domain
   logic frame_rst;
   logic oe_clr;
   sfce_phase_e phase_r;
   logic [4:0] cnt_r;
   logic [15:0] rx_r;
   logic [15:0] rx_nxt;
   logic [7:0] op_r;
   logic [AW-1:0] addr_r;
   logic [AW-1:0] addr_in;
   logic [31:0] tx_r;
   logic [SPARE_HI_BIT+1:BLOCK_GUARD_LOW_BIT] sr_r;
   logic latch_r;
   logic sleep_req_r;
   logic [7:0] status_byte;
   logic op_done;
   logic addr_done;
   logic byte_done;
   logic mem_wr_en;
   logic [AW-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic reading;

   // power-on reset for the link domain, held while rst_n is low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         por_r <= 1'b1;
      end else begin
         por_r <= 1'b0;
      end
   end

   sfce_sync #(.RST_VAL(1'b1)) u_cs_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(cs_n),
      .q(cs_s)
   );

   sfce_sync #(.RST_VAL(1'b0)) u_req_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(sleep_req_r),
      .q(req_s)
   );

   // select edges as seen by the system clock
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_prev_r <= 1'b1;
      end else begin
         cs_prev_r <= cs_s;
      end
   end

   assign cs_rise = cs_s && !cs_prev_r;
   assign cs_fall = !cs_s && cs_prev_r;
   assign sleep_go = !asleep_r && cs_rise && req_s && !req_used_r;
   assign wake_done = waking_r && (wake_cnt_r == WAKE_LAST);

   // the request level is consumed once so an empty frame cannot re-enter sleep
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         req_used_r <= 1'b0;
      end else if (sleep_go) begin
         req_used_r <= 1'b1;
      end else if (!req_s) begin
         req_used_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         asleep_r <= 1'b0;
      end else if (sleep_go) begin
         asleep_r <= 1'b1;
      end else if (wake_done) begin
         asleep_r <= 1'b0;
      end
   end

   // a falling select while asleep starts the wake wait; a later rise does not stop it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         waking_r <= 1'b0;
      end else if (wake_done) begin
         waking_r <= 1'b0;
      end else if (asleep_r && cs_fall) begin
         waking_r <= 1'b1;
      end
   end

   // counter accounts for sync delay so release stays inside the wake time
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wake_cnt_r <= '0;
      end else if (!waking_r) begin
         wake_cnt_r <= '0;
      end else if (!wake_done) begin
         wake_cnt_r <= wake_cnt_r + 1'b1;
      end
   end

   assign asleep = asleep_r;

   // deselect, sleep and power-on all park the link logic
   assign frame_rst = cs_n | asleep_r | por_r;
   assign oe_clr = frame_rst | !hold_n;

   assign rx_nxt = {rx_r[14:0], si};
   assign addr_in = rx_nxt[AW-1:0];
   assign status_byte = {sr_r, latch_r, 1'b0};
   assign op_done = hold_n && (phase_r == PH_OPCODE) && (cnt_r == 5'(OP_BITS - 1));
   assign addr_done = hold_n && (phase_r == PH_ADDR) && (cnt_r == 5'(ADDR_BITS - 1));
   assign byte_done = hold_n && (cnt_r == 5'(DATA_W - 1));
   assign rd_addr = (phase_r == PH_ADDR) ? addr_in : addr_r;
   assign mem_wr_en = byte_done && (phase_r == PH_MEM_WR) && latch_r
      && !sfce_guarded(addr_r, sr_r[BLOCK_GUARD_HIGH_BIT:BLOCK_GUARD_LOW_BIT]);
   assign reading = (phase_r == PH_STAT_RD) || (phase_r == PH_MEM_RD) || (phase_r == PH_ID_RD);

   sfce_array #(.DEPTH(DEPTH), .AW(AW), .DW(DATA_W)) u_array (
      .clk(sck),
      .wr_en(mem_wr_en),
      .wr_addr(addr_r),
      .wr_data(rx_nxt[DATA_W-1:0]),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // input shifter, sampled on rising edges
   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         rx_r <= '0;
      end else if (hold_n) begin
         rx_r <= rx_nxt;
      end
   end

   // command phase sequencing
   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         phase_r <= PH_OPCODE;
         cnt_r <= '0;
      end else if (hold_n) begin
         case (phase_r)
            PH_OPCODE: begin
               cnt_r <= (cnt_r == 5'(OP_BITS - 1)) ? 5'd0 : cnt_r + 5'd1;
               if (cnt_r == 5'(OP_BITS - 1)) begin
                  case (rx_nxt[7:0])
                     STATUS_READ_CMD: phase_r <= PH_STAT_RD;
                     STATUS_WRITE_CMD: phase_r <= PH_STAT_WR;
                     ARRAY_READ_CMD: phase_r <= PH_ADDR;
                     ARRAY_WRITE_CMD: phase_r <= PH_ADDR;
                     IDENTITY_READ_CMD: phase_r <= PH_ID_RD;
                     // latch codes, sleep, reserved and unknown codes need no more bits
                     default: phase_r <= PH_IDLE;
                  endcase
               end
            end
            PH_ADDR: begin
               cnt_r <= (cnt_r == 5'(ADDR_BITS - 1)) ? 5'd0 : cnt_r + 5'd1;
               if (cnt_r == 5'(ADDR_BITS - 1)) begin
                  phase_r <= (op_r == ARRAY_READ_CMD) ? PH_MEM_RD : PH_MEM_WR;
               end
            end
            PH_STAT_RD, PH_MEM_RD, PH_MEM_WR: begin
               cnt_r <= (cnt_r == 5'(DATA_W - 1)) ? 5'd0 : cnt_r + 5'd1;
            end
            PH_STAT_WR: begin
               // one byte only; later clocks are ignored
               if (cnt_r == 5'(DATA_W - 1)) begin
                  phase_r <= PH_IDLE;
               end else begin
                  cnt_r <= cnt_r + 5'd1;
               end
            end
            PH_ID_RD: begin
               if (cnt_r != 5'(ID_BITS - 1)) begin
                  cnt_r <= cnt_r + 5'd1;
               end
            end
            default: begin
               cnt_r <= cnt_r;
            end
         endcase
      end
   end

   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         op_r <= 8'h00;
      end else if (op_done) begin
         op_r <= rx_nxt[7:0];
      end
   end

   // address counter; wraps naturally at the array size
   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         addr_r <= '0;
      end else if (addr_done) begin
         addr_r <= (op_r == ARRAY_READ_CMD) ? addr_in + 1'b1 : addr_in;
      end else if (byte_done && (phase_r == PH_MEM_RD || phase_r == PH_MEM_WR)) begin
         addr_r <= addr_r + 1'b1;
      end
   end

   // output shifter: loaded on the rising edge, msb presented on the following falling edge
   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         tx_r <= '0;
      end else if (op_done && rx_nxt[7:0] == STATUS_READ_CMD) begin
         tx_r <= {status_byte, 24'h00_0000};
      end else if (op_done && rx_nxt[7:0] == IDENTITY_READ_CMD) begin
         tx_r <= ID_WORD;
      end else if (addr_done && op_r == ARRAY_READ_CMD) begin
         tx_r <= {rd_data, 24'h00_0000};
      end else if (hold_n) begin
         case (phase_r)
            PH_STAT_RD: begin
               tx_r <= byte_done ? {status_byte, 24'h00_0000} : {tx_r[30:0], 1'b0};
            end
            PH_MEM_RD: begin
               tx_r <= byte_done ? {rd_data, 24'h00_0000} : {tx_r[30:0], 1'b0};
            end
            PH_ID_RD: begin
               // last bit parks in the msb and stays there
               if (cnt_r != 5'(ID_BITS - 1)) begin
                  tx_r <= {tx_r[30:0], 1'b0};
               end
            end
            default: begin
               tx_r <= tx_r;
            end
         endcase
      end
   end

   always_ff @(negedge sck or posedge oe_clr) begin
      if (oe_clr) begin
         so <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         so <= tx_r[31];
         so_oe <= reading;
      end
   end

   // latch and status bits survive deselect and sleep; only power-on resets them
   always_ff @(posedge sck or posedge por_r) begin
      if (por_r) begin
         latch_r <= STATUS_RESET[LATCH_BIT];
      end else if (op_done && !asleep_r && !cs_n) begin
         // an aborted opcode never reaches here, so the latch keeps its value
         if (rx_nxt[7:0] == LATCH_SET_CMD) begin
            latch_r <= 1'b1;
         end else if (rx_nxt[7:0] == LATCH_CLEAR_CMD) begin
            latch_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sck or posedge por_r) begin
      if (por_r) begin
         sr_r <= STATUS_RESET[STATUS_LOCK_BIT:BLOCK_GUARD_LOW_BIT];
      end else if (!frame_rst && byte_done && phase_r == PH_STAT_WR && latch_r
                   && !(sr_r[STATUS_LOCK_BIT] && !wp_n)) begin
         sr_r <= rx_nxt[STATUS_LOCK_BIT:BLOCK_GUARD_LOW_BIT];
      end
   end

   // request holds from the opcode edge to the next rising edge, which cancels it
   always_ff @(posedge sck or posedge por_r) begin
      if (por_r) begin
         sleep_req_r <= 1'b0;
      end else if (!frame_rst && hold_n) begin
         sleep_req_r <= op_done && (rx_nxt[7:0] == SLEEP_CMD);
      end
   end

endmodule

// [inc/sfce_pkg.sv]
// shared constants of the serial ferroelectric-memory command engine
// assumes: link in clock modes 0/3, msb first, 200 MHz system clock for the wake timer
package sfce_pkg;

   // instruction codes
   localparam logic [7:0] LATCH_SET_CMD = 8'h06;
   localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
   localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
   localparam logic [7:0] IDENTITY_READ_CMD = 8'h9F;
   localparam logic [7:0] SLEEP_CMD = 8'hB9;
   localparam logic [7:0] RESERVED_CODE = 8'h0B;

   // array geometry
   localparam int ARRAY_DEPTH = 8192;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;

   // field lengths on the link, in bits
   localparam int OP_BITS = 8;
   localparam int ADDR_BITS = 16;
   localparam int ID_BITS = 32;

   // status byte layout
   localparam int STATUS_LOCK_BIT = 7;
   localparam int SPARE_HI_BIT = 6;
   localparam int SPARE_LO_BIT = 4;
   localparam int BLOCK_GUARD_HIGH_BIT = 3;
   localparam int BLOCK_GUARD_LOW_BIT = 2;
   localparam int LATCH_BIT = 1;
   localparam int ZERO_BIT = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // guarded region bases, all regions end at the top of the array
   localparam logic [ADDR_W-1:0] GUARD_QUARTER_BASE = 13'h1800;
   localparam logic [ADDR_W-1:0] GUARD_HALF_BASE = 13'h1000;

   // identity word: maker, continuation, product hi, product lo (arbitrary values)
   localparam logic [31:0] ID_WORD_DEFAULT = 32'h0A7F_055A;

   // wake-up from sleep
   localparam int WAKE_TIME_US = 400;
   localparam int CLK_FREQ_MHZ = 200;
   localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_FREQ_MHZ;
   // synchroniser + edge detect + release cycles spent outside the counter
   localparam int WAKE_OVERHEAD = 4;

   typedef enum logic [2:0] {
      PH_OPCODE,
      PH_ADDR,
      PH_MEM_RD,
      PH_MEM_WR,
      PH_STAT_RD,
      PH_STAT_WR,
      PH_ID_RD,
      PH_IDLE
   } sfce_phase_e;

   // true when addr lies in the region selected by the two guard bits
   function automatic logic sfce_guarded(input logic [ADDR_W-1:0] addr, input logic [1:0] guard);
      logic hit;
      hit = 1'b0;
      case (guard)
         2'b01: hit = (addr >= GUARD_QUARTER_BASE);
         2'b10: hit = (addr >= GUARD_HALF_BASE);
         2'b11: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

endpackage

// [testbench/sfce_master.sv]
// model of the link master: 6 ns link clock, running only inside frames
// assumes: the bench calls one task at a time
`timescale 1ns/10ps
module sfce_master (
   output logic sck,
   output logic cs_n,
   output logic si,
   output logic hold_n,
   input logic so,
   input logic so_oe
);
   logic cpol = 1'b0;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
   end
   // top n bits of tx out, msb first; a floating so reads as its inverse
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         si = tx[i];
         sck = 1'b0;
         #3;
         sck = 1'b1;
         rx[i] = so_oe ? so : ~so;
         #3;
      end
   endtask
   task automatic sel();
      sck = cpol;
      #3;
      cs_n = 1'b0;
      #6;
   endtask
   // gap long enough for sleep detection
   task automatic desel();
      #3;
      sck = cpol;
      #3;
      cs_n = 1'b1;
      #20;
   endtask
   // clock wiggles in hold are ignored; release at the level hold began
   task automatic pause();
      hold_n = 1'b0;
      repeat (4) begin
         #3;
         sck = ~sck;
      end
      #3;
      hold_n = 1'b1;
      #3;
   endtask
endmodule

// [testbench/sfce_top_chk.sv]
// port checker for the command engine, bound into sfce_top
// assumes: frames in mode 0 or 3, hold only with the link clock parked
`timescale 1ns/10ps
module sfce_top_chk
   import sfce_pkg::*;
#(
   parameter int WAKE_CYC = 20
) (
   input logic clk,
   input logic rst_n,
   input logic sck,
   input logic cs_n,
   input logic si,
   input logic hold_n,
   input logic wp_n,
   input logic so,
   input logic so_oe,
   input logic asleep
);
   logic [7:0] op_r;
   logic [6:0] cnt_r;
   int wk_r;
   // own opcode decode, frozen in hold like the engine
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         op_r <= 8'h00;
         cnt_r <= 7'h00;
      end else if (hold_n) begin
         if (cnt_r < 7'h08) op_r <= {op_r[6:0], si};
         if (cnt_r != 7'h7F) cnt_r <= cnt_r + 7'h01;
      end
   end
   // clk edges since select fell while asleep
   always_ff @(posedge clk) begin
      if (!rst_n || !asleep) wk_r <= 0;
      else if (!cs_n || wk_r != 0) wk_r <= wk_r + 1;
   end
   chk_standby_float: assert property (@(posedge clk) disable iff (!rst_n) cs_n && $past(cs_n) |-> !so_oe)
      else $error("so driven while deselected");
   chk_hold_float: assert property (@(posedge clk) disable iff (!rst_n) !hold_n && $past(!hold_n) |-> !so_oe)
      else $error("so driven in hold");
   chk_sleep_float: assert property (@(posedge clk) disable iff (!rst_n) asleep && $past(asleep) |-> !so_oe)
      else $error("so driven while asleep");
   chk_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n) $rose(asleep) |-> cs_n)
      else $error("sleep entered while selected");
   chk_wake_bound: assert property (@(posedge clk) disable iff (!rst_n) wk_r <= WAKE_CYC)
      else $error("wake took too long");
   chk_wake_cause: assert property (@(posedge clk) disable iff (!rst_n) $fell(asleep) |-> wk_r != 0)
      else $error("woke without select");
   chk_read_drive: assert property (@(negedge sck) disable iff (cs_n)
      hold_n && ((op_r == STATUS_READ_CMD || op_r == IDENTITY_READ_CMD) && cnt_r == 7'h09 ||
      op_r == ARRAY_READ_CMD && cnt_r == 7'h19) |-> so_oe)
      else $error("read data not driven in time");
   chk_write_quiet: assert property (@(negedge sck) disable iff (cs_n)
      (op_r == ARRAY_WRITE_CMD || op_r == STATUS_WRITE_CMD) && cnt_r > 7'h08 |-> !so_oe)
      else $error("so driven during a write");
   chk_id_last: assert property (@(negedge sck) disable iff (cs_n)
      op_r == IDENTITY_READ_CMD && cnt_r >= 7'h29 && hold_n |-> $stable(so))
      else $error("identity last bit not held");
   chk_status_rpt: assert property (@(negedge sck) disable iff (cs_n)
      op_r == STATUS_READ_CMD && cnt_r >= 7'h11 && hold_n |-> so == $past(so, 8))
      else $error("status byte not repeated");
endmodule

bind sfce_top sfce_top_chk #(.WAKE_CYC(WAKE_CYC)) u_chk (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
   .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .asleep(asleep));

// [testbench/sfce_top_tb.sv]
// self-checking bench of the command engine with the link master model
// assumes: short wake count; array contents written before being read
`timescale 1ns/10ps
module sfce_top_tb;
   import sfce_pkg::*;
   localparam int WAKE = 200;
   // arbitrary identity word
   localparam logic [31:0] ID = 32'h5A3C_96E1;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp_n = 1'b1;
   logic sck, cs_n, si, hold_n, so, so_oe, asleep;
   logic [7:0] rx;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   sfce_top #(.WAKE_CYC(WAKE), .ID_WORD(ID), .DEPTH(ARRAY_DEPTH)) dut (.clk(clk), .rst_n(rst_n), .sck(sck),
      .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .asleep(asleep));
   sfce_master m (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
   task automatic report_and_stop();
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // only defined instruction codes are ever sent
   task automatic op2(input logic [7:0] op, input logic [7:0] b, input int n);
      m.sel();
      m.xfer(op, 8, rx);
      repeat (n) m.xfer(b, 8, rx);
      m.desel();
   endtask
   // third byte of a long read must still be the status byte
   task automatic rd_status(output logic [7:0] st);
      op2(STATUS_READ_CMD, 8'h00, 3);
      st = rx;
   endtask
   task automatic wr_status(input logic [7:0] v);
      op2(LATCH_SET_CMD, 8'h00, 0);
      op2(STATUS_WRITE_CMD, v, 1);
   endtask
   // opcode, address, data bytes; optional hold before byte h
   task automatic mem(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d[$], output logic [7:0] q[$],
      input int h);
      m.sel();
      m.xfer(op, 8, rx);
      m.xfer(a[15:8], 8, rx);
      m.xfer(a[7:0], 8, rx);
      q = {};
      foreach (d[i]) begin
         if (i == h) m.pause();
         m.xfer(d[i], 8, rx);
         q.push_back(rx);
      end
      m.desel();
   endtask
   task automatic t_latch();
      for (int p = 0; p < 2; p++) begin
         m.cpol = p[0];
         rd_status(rx);
         check("status", 8'h00, rx);
         op2(LATCH_SET_CMD, 8'h00, 0);
         rd_status(rx);
         check("latch set", 8'h02, rx);
         op2(LATCH_CLEAR_CMD, 8'h00, 0);
         rd_status(rx);
         check("latch clear", 8'h00, rx);
      end
      m.cpol = 1'b0;
   endtask
   task automatic t_abort();
      m.sel();
      m.xfer(LATCH_SET_CMD, 7, rx);
      m.desel();
      rd_status(rx);
      check("cut opcode", 8'h00, rx);
      // latch set first, so an abort that wrongly clears it shows up
      op2(LATCH_SET_CMD, 8'h00, 0);
      m.sel();
      m.xfer(LATCH_CLEAR_CMD, 7, rx);
      m.hold_n = 1'b0;
      m.desel();
      m.hold_n = 1'b1;
      rd_status(rx);
      check("hold abort", 8'h02, rx);
      op2(LATCH_CLEAR_CMD, 8'h00, 0);
   endtask
   task automatic t_status();
      op2(STATUS_WRITE_CMD, 8'h8C, 1);
      rd_status(rx);
      check("status refused", 8'h00, rx);
      wr_status(8'hFF);
      rd_status(rx);
      check("status write", 8'hFE, rx);
      @(negedge clk) wp_n = 1'b0;
      wr_status(8'h00);
      rd_status(rx);
      check("status locked", 8'hFE, rx);
      @(negedge clk) wp_n = 1'b1;
      wr_status(8'h00);
      rd_status(rx);
      check("status unlocked", 8'h02, rx);
   endtask
   task automatic t_write();
      logic [7:0] q[$];
      mem(ARRAY_WRITE_CMD, 16'h0010, '{8'h3C}, q, -1);
      op2(LATCH_CLEAR_CMD, 8'h00, 0);
      mem(ARRAY_WRITE_CMD, 16'h0010, '{8'hA5}, q, -1);
      op2(LATCH_SET_CMD, 8'h00, 0);
      mem(ARRAY_WRITE_CMD, 16'hFFFF, '{8'h11, 8'h22}, q, -1);
      mem(ARRAY_READ_CMD, 16'h0010, '{8'h00}, q, -1);
      check("refused write", 8'h3C, q[0]);
      mem(ARRAY_READ_CMD, 16'hFFFF, '{8'h00, 8'h00}, q, 1);
      check("top byte", 8'h11, q[0]);
      check("wrapped byte", 8'h22, q[1]);
   endtask
   task automatic t_guard();
      logic [7:0] q[$];
      logic [15:0] a[5] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h17FF, 16'h1800};
      logic prot;
      for (int g = 0; g < 4; g++) begin
         wr_status(8'h00);
         foreach (a[i]) mem(ARRAY_WRITE_CMD, a[i], '{8'h00}, q, -1);
         wr_status({4'h0, g[1:0], 2'h0});
         foreach (a[i]) mem(ARRAY_WRITE_CMD, a[i], '{8'hC3}, q, -1);
         foreach (a[i]) begin
            prot = g == 3 || g == 2 && a[i] >= 16'h1000 || g == 1 && a[i] >= 16'h1800;
            mem(ARRAY_READ_CMD, a[i], '{8'h00}, q, -1);
            check("guarded write", prot ? 8'h00 : 8'hC3, q[0]);
         end
      end
      wr_status(8'h00);
   endtask
   task automatic t_ident();
      m.sel();
      m.xfer(IDENTITY_READ_CMD, 8, rx);
      for (int i = 0; i < 6; i++) begin
         m.xfer(8'h00, 8, rx);
         check("identity", i < 4 ? ID[31-8*i -: 8] : {8{ID[0]}}, rx);
      end
      m.desel();
   endtask
   task automatic t_sleep();
      m.sel();
      m.xfer(SLEEP_CMD, 8, rx);
      m.xfer(8'h00, 1, rx);
      m.desel();
      repeat (8) @(negedge clk);
      check("sleep cancelled", 8'h00, {7'h00, asleep});
      op2(SLEEP_CMD, 8'h00, 0);
      repeat (8) @(negedge clk);
      check("asleep", 8'h01, {7'h00, asleep});
      op2(LATCH_CLEAR_CMD, 8'h00, 0);
      repeat (WAKE + 4) @(negedge clk);
      check("awake", 8'h00, {7'h00, asleep});
      rd_status(rx);
      check("ignored asleep", 8'h02, rx);
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_latch();
      t_abort();
      t_status();
      t_write();
      t_guard();
      t_ident();
      t_sleep();
      report_and_stop();
   end
endmodule
